// ===== src/dma4_arb.sv
// Fixed priority picker: lowest numbered requesting channel wins
// Assumes request bits are from logic on the same clock
`timescale 1ns/1ps
module dma4_arb (
  input  wire logic [3:0] req,
  output logic            grant_vld,
  output logic      [1:0] grant_idx
);
  // ------------------------------------------------------------------
  // Priority scan
  // ------------------------------------------------------------------
  // Scan from low priority up so channel zero is taken last and wins
  always_comb
  begin
    grant_idx = 2'h0;
    for (int i = 3; i >= 0; i--)
    begin
      if (req[i])
        grant_idx = i[1:0];
    end
  end

  assign grant_vld = |req;
endmodule

// ===== src/dma4_core.sv
// Four-channel dual-address DMA engine with APB register slave
// Assumes a system bus that answers each request with bus_ack or bus_err
`timescale 1ns/1ps
module dma4_core (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  periph_req,
  output logic             bus_req,
  output logic             bus_wr,
  output logic      [31:0] bus_addr,
  output logic      [2:0]  bus_bytes,
  output logic      [31:0] bus_wdata,
  input  wire logic [31:0] bus_rdata,
  input  wire logic        bus_ack,
  input  wire logic        bus_err,
  output logic      [3:0]  irq
);
  localparam int N = dma4_pkg::NCH;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic [31:0] sar_q [N];
  logic [31:0] dar_q [N];
  logic [23:0] bcr_q [N];
  logic [31:0] dcr_q [N];
  logic [N-1:0] ce_q, bes_q, bed_q, done_q, req_q, bsy;
  dma4_pkg::dma4_state_t st_q, st_d;
  logic [1:0]  ch_q;
  logic [2:0]  xfer_q, got_q, put_q, bytes_q;
  logic [31:0] hold_q, addr_q, wdata_q, prdata_q;
  logic        wr_q;

  // ------------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------------
  logic        hit, sw_wr, sw_abort, run;
  logic [1:0]  rch;
  logic [3:0]  roff;
  logic [N-1:0] wr_ch, done_clr, chan_req;
  logic [31:0] rd_mux;

  // Word-aligned addresses in the low 64 bytes are mapped, zero wait
  assign hit     = (paddr[7:6] == 2'h0) & (paddr[1:0] == 2'h0);
  assign rch     = paddr[5:4];
  assign roff    = paddr[3:0];
  assign sw_wr   = psel & penable & pwrite & hit;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata  = prdata_q;

  // Per-channel write strobes, requests and status
  generate
    for (genvar g = 0; g < N; g++)
    begin : g_ch
      assign wr_ch[g]    = sw_wr & (rch == g[1:0]);
      assign done_clr[g] = wr_ch[g] & (roff == dma4_pkg::OFF_DSR) & pwdata[dma4_pkg::DSR_DONE];
      assign chan_req[g] = ~done_q[g] & (dcr_q[g][dma4_pkg::DCR_START]
                         | (dcr_q[g][dma4_pkg::DCR_ERQ] & periph_req[g]));
      assign bsy[g]      = (st_q != dma4_pkg::ST_IDLE) & (ch_q == g[1:0]);
      assign irq[g]      = done_q[g] & dcr_q[g][dma4_pkg::DCR_IRQ_ON_COMPLETION_ENABLE];
    end
  endgenerate

  // Read data selection
  assign rd_mux = (roff == dma4_pkg::OFF_SAR) ? sar_q[rch] :
                  (roff == dma4_pkg::OFF_DAR) ? dar_q[rch] :
                  (roff == dma4_pkg::OFF_DCR) ? dcr_q[rch] :
                  {1'b0, ce_q[rch], bes_q[rch], bed_q[rch], 1'b0,
                   req_q[rch], bsy[rch], done_q[rch], bcr_q[rch]};

  // Read data is captured in the setup phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= dma4_pkg::RST_WORD;
    else if (psel & ~penable & ~pwrite)
      prdata_q <= hit ? rd_mux : dma4_pkg::RST_WORD;
  end

  // ------------------------------------------------------------------
  // Current channel view
  // ------------------------------------------------------------------
  logic [31:0] cur_dcr, cur_sar, cur_dar;
  logic [23:0] cur_bcr;
  logic [2:0]  sb, db, big, xfer_d, rd_beat, wr_beat, got_nxt, put_nxt;
  logic        src_al, dst_al, cfg_err, grant_vld;
  logic [1:0]  grant_idx, x_addr, w_addr;
  logic [2:0]  x_max;

  assign cur_dcr = dcr_q[ch_q];
  assign cur_sar = sar_q[ch_q];
  assign cur_dar = dar_q[ch_q];
  assign cur_bcr = bcr_q[ch_q];
  assign sb      = dma4_pkg::bytes_of(cur_dcr[dma4_pkg::DCR_SSZ +: 2]);
  assign db      = dma4_pkg::bytes_of(cur_dcr[dma4_pkg::DCR_DSZ +: 2]);
  assign big     = (sb >= db) ? sb : db;

  // Wider side is aligned, source on a tie
  assign src_al  = cur_dcr[dma4_pkg::DCR_AA] & (sb >= db);
  assign dst_al  = cur_dcr[dma4_pkg::DCR_AA] & (sb < db);

  // Width checks skip the aligned side; reserved codes and zero count fail
  assign cfg_err = (cur_dcr[dma4_pkg::DCR_SSZ +: 2] == 2'h3)
                 | (cur_dcr[dma4_pkg::DCR_DSZ +: 2] == 2'h3)
                 | (~src_al & dma4_pkg::misaligned(cur_sar[1:0], sb))
                 | (~dst_al & dma4_pkg::misaligned(cur_dar[1:0], db))
                 | (cur_bcr == 24'h00_0000);

  // Transfer size: aligned side follows address and count, else widest the count allows
  assign x_addr = src_al ? cur_sar[1:0] : dst_al ? cur_dar[1:0] : 2'h0;
  assign x_max  = src_al ? sb : dst_al ? db : big;
  assign w_addr = cur_dar[1:0] + put_q[1:0];
  assign got_nxt = got_q + bytes_q;
  assign put_nxt = put_q + bytes_q;

  dma4_fit u_fit_xfer (
    .addr_lo   (x_addr),
    .max_bytes (x_max),
    .remain    (cur_bcr),
    .fit_bytes (xfer_d)
  );

  dma4_fit u_fit_rd (
    .addr_lo   (cur_sar[1:0]),
    .max_bytes (sb),
    .remain    ({21'h0, xfer_q - got_q}),
    .fit_bytes (rd_beat)
  );

  dma4_fit u_fit_wr (
    .addr_lo   (w_addr),
    .max_bytes (db),
    .remain    ({21'h0, xfer_q - put_q}),
    .fit_bytes (wr_beat)
  );

  dma4_arb u_arb (
    .req       (chan_req),
    .grant_vld (grant_vld),
    .grant_idx (grant_idx)
  );

  // ------------------------------------------------------------------
  // Engine events
  // ------------------------------------------------------------------
  logic rd_wt, wr_wt, rd_ok, wr_ok, rd_err, wr_err, e_act;
  logic e_cfg, e_go, e_source_increment, e_wlast, e_fin, e_done, e_idle;

  // Writing done to the active channel stops it at once
  assign sw_abort = done_clr[ch_q] & (st_q != dma4_pkg::ST_IDLE);
  assign run      = ~sw_abort;
  assign rd_wt    = st_q == dma4_pkg::ST_RD_WAIT;
  assign wr_wt    = st_q == dma4_pkg::ST_WR_WAIT;
  assign rd_ok    = rd_wt & bus_ack & ~bus_err & run;
  assign wr_ok    = wr_wt & bus_ack & ~bus_err & run;
  assign rd_err   = rd_wt & bus_err & run;
  assign wr_err   = wr_wt & bus_err & run;
  assign e_act    = (st_q == dma4_pkg::ST_IDLE) & grant_vld;
  assign e_cfg    = (st_q == dma4_pkg::ST_CHECK) & cfg_err & run;
  assign e_go     = (st_q == dma4_pkg::ST_CHECK) & ~cfg_err & run;
  assign e_source_increment   = rd_ok & (cur_dcr[dma4_pkg::DCR_SOURCE_INCREMENT] | src_al);
  assign e_wlast  = wr_ok & (put_nxt == xfer_q);
  assign e_fin    = (st_q == dma4_pkg::ST_NEXT) & (cur_bcr == 24'h00_0000) & run;
  assign e_done   = e_cfg | rd_err | wr_err | e_fin;
  assign e_idle   = (st_d == dma4_pkg::ST_IDLE) & (st_q != dma4_pkg::ST_IDLE);

  // Next state of the transfer sequencer
  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      dma4_pkg::ST_IDLE:    if (grant_vld) st_d = dma4_pkg::ST_CHECK;
      dma4_pkg::ST_CHECK:   st_d = cfg_err ? dma4_pkg::ST_IDLE : dma4_pkg::ST_RD_SET;
      dma4_pkg::ST_RD_SET:  st_d = dma4_pkg::ST_RD_WAIT;
      dma4_pkg::ST_RD_WAIT:
        if (bus_err)
          st_d = dma4_pkg::ST_IDLE;
        else if (bus_ack)
          st_d = (got_nxt == xfer_q) ? dma4_pkg::ST_WR_SET : dma4_pkg::ST_RD_SET;
      dma4_pkg::ST_WR_SET:  st_d = dma4_pkg::ST_WR_WAIT;
      dma4_pkg::ST_WR_WAIT:
        if (bus_err)
          st_d = dma4_pkg::ST_IDLE;
        else if (bus_ack)
          st_d = (put_nxt == xfer_q) ? dma4_pkg::ST_NEXT : dma4_pkg::ST_WR_SET;
      dma4_pkg::ST_NEXT:
        st_d = ((cur_bcr != 24'h00_0000) & ~cur_dcr[dma4_pkg::DCR_CS])
             ? dma4_pkg::ST_CHECK : dma4_pkg::ST_IDLE;
      default: st_d = dma4_pkg::ST_IDLE;
    endcase
    if (sw_abort)
      st_d = dma4_pkg::ST_IDLE;
  end

  // ------------------------------------------------------------------
  // Sequencer registers
  // ------------------------------------------------------------------
  // Channel is latched only from idle, so a running channel keeps the bus
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= dma4_pkg::ST_IDLE;
      ch_q <= 2'h0;
    end
    else
    begin
      st_q <= st_d;
      if (e_act)
        ch_q <= grant_idx;
    end
  end

  // Beat counters and holding register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      xfer_q <= 3'h0;
      got_q  <= 3'h0;
      put_q  <= 3'h0;
      hold_q <= dma4_pkg::RST_WORD;
    end
    else if (e_go)
    begin
      xfer_q <= xfer_d;
      got_q  <= 3'h0;
      put_q  <= 3'h0;
      hold_q <= dma4_pkg::RST_WORD;
    end
    else if (rd_ok)
    begin
      got_q  <= got_nxt;
      hold_q <= hold_q | ((bus_rdata & dma4_pkg::lane_mask(bytes_q)) << {got_q, 3'h0});
    end
    else if (wr_ok)
      put_q <= put_nxt;
    else if (wr_err)
      hold_q <= dma4_pkg::RST_WORD;
  end

  // Bus request fields are loaded one cycle before the request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      addr_q  <= dma4_pkg::RST_WORD;
      bytes_q <= 3'h0;
      wr_q    <= 1'b0;
      wdata_q <= dma4_pkg::RST_WORD;
    end
    else if (st_q == dma4_pkg::ST_RD_SET)
    begin
      addr_q  <= cur_sar;
      bytes_q <= rd_beat;
      wr_q    <= 1'b0;
    end
    else if (st_q == dma4_pkg::ST_WR_SET)
    begin
      addr_q  <= cur_dar + {29'h0, put_q};
      bytes_q <= wr_beat;
      wr_q    <= 1'b1;
      wdata_q <= (hold_q >> {put_q, 3'h0}) & dma4_pkg::lane_mask(wr_beat);
    end
  end

  assign bus_req   = rd_wt | wr_wt;
  assign bus_wr    = wr_q;
  assign bus_addr  = addr_q;
  assign bus_bytes = bytes_q;
  assign bus_wdata = wdata_q;

  // ------------------------------------------------------------------
  // Channel registers
  // ------------------------------------------------------------------
  // Hardware steps first, then software writes; flag sets follow clears
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int n = 0; n < N; n++)
      begin
        sar_q[n] <= dma4_pkg::RST_WORD;
        dar_q[n] <= dma4_pkg::RST_WORD;
        bcr_q[n] <= 24'h00_0000;
        dcr_q[n] <= dma4_pkg::RST_WORD;
      end
      {ce_q, bes_q, bed_q, done_q, req_q} <= '0;
    end
    else
    begin
      for (int n = 0; n < N; n++)
      begin
        if (e_act & (grant_idx == n[1:0]))
          dcr_q[n][dma4_pkg::DCR_START] <= 1'b0;
        if ((ch_q == n[1:0]) & e_source_increment)
          sar_q[n] <= sar_q[n] + {29'h0, bytes_q};
        if ((ch_q == n[1:0]) & e_wlast)
        begin
          if (dcr_q[n][dma4_pkg::DCR_DEST_INCREMENT] | dst_al)
            dar_q[n] <= dar_q[n] + {29'h0, xfer_q};
          bcr_q[n] <= bcr_q[n] - {21'h0, xfer_q};
        end
        if ((ch_q == n[1:0]) & e_fin & dcr_q[n][dma4_pkg::DCR_DREQ])
          dcr_q[n][dma4_pkg::DCR_ERQ] <= 1'b0;
        if (wr_ch[n] & (roff == dma4_pkg::OFF_SAR))
          sar_q[n] <= pwdata;
        if (wr_ch[n] & (roff == dma4_pkg::OFF_DAR))
          dar_q[n] <= pwdata;
        if (wr_ch[n] & (roff == dma4_pkg::OFF_DSR))
          bcr_q[n] <= pwdata[23:0];
        if (wr_ch[n] & (roff == dma4_pkg::OFF_DCR))
          dcr_q[n] <= pwdata & dma4_pkg::DCR_MASK;
        if (done_clr[n])
        begin
          {ce_q[n], bes_q[n], bed_q[n], done_q[n], req_q[n]} <= 5'h00;
        end
        if (ch_q == n[1:0])
        begin
          if (e_idle)
            req_q[n] <= 1'b0;
          if (e_go)
            req_q[n] <= 1'b1;
          if (e_cfg)
            ce_q[n] <= 1'b1;
          if (rd_err)
            bes_q[n] <= 1'b1;
          if (wr_err)
            bed_q[n] <= 1'b1;
          if (e_done)
            done_q[n] <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_start_clear: assert property (
    (e_act && !sw_wr) |=> !dcr_q[ch_q][dma4_pkg::DCR_START])
    else $error("start bit not cleared on activation");
  a_cfg_halt: assert property (
    e_cfg |=> (st_q == dma4_pkg::ST_IDLE) && ce_q[ch_q] && done_q[ch_q] && !bus_req)
    else $error("config error did not halt the channel");
  a_xfer_size: assert property (
    (e_go && !cur_dcr[dma4_pkg::DCR_AA] && cur_bcr >= 24'h00_0004) |=> xfer_q == $past(big))
    else $error("transfer size is not the larger width");
  a_steal_once: assert property (
    (st_q == dma4_pkg::ST_NEXT && cur_dcr[dma4_pkg::DCR_CS]) |=> st_q == dma4_pkg::ST_IDLE)
    else $error("cycle-steal ran more than one transfer");
  a_cont_more: assert property (
    (st_q == dma4_pkg::ST_NEXT && run && !cur_dcr[dma4_pkg::DCR_CS]
     && cur_bcr != 24'h00_0000) |=> st_q == dma4_pkg::ST_CHECK)
    else $error("continuous mode stopped early");
  a_prio_zero: assert property (
    (st_q == dma4_pkg::ST_IDLE && chan_req[0]) |=> ch_q == 2'h0)
    else $error("channel zero lost arbitration");
  a_no_preempt: assert property (
    (st_q != dma4_pkg::ST_IDLE) |=> $stable(ch_q))
    else $error("active channel was preempted");
  a_sar_step: assert property (
    (e_source_increment && !sw_wr) |=> cur_sar == $past(cur_sar) + {29'h0, $past(bytes_q)})
    else $error("source address step wrong");
  a_bcr_step: assert property (
    (e_wlast && !sw_wr) |=> cur_bcr == $past(cur_bcr) - {21'h0, $past(xfer_q)})
    else $error("byte count step wrong");
  a_erq_auto: assert property (
    (e_fin && cur_dcr[dma4_pkg::DCR_DREQ] && !sw_wr) |=> !cur_dcr[dma4_pkg::DCR_ERQ])
    else $error("request enable not cleared at zero count");
  a_rd_error: assert property (
    rd_err |=> bes_q[ch_q] && done_q[ch_q] && st_q == dma4_pkg::ST_IDLE)
    else $error("read error not flagged");
  a_req_stat: assert property (
    e_go |=> req_q[ch_q] ##1 bus_req)
    else $error("pending status or read request missing");

  c_cont_pass: cover property (st_q == dma4_pkg::ST_NEXT ##1 st_q == dma4_pkg::ST_CHECK);
  c_wr_error:  cover property (wr_err);
  c_cfg_error: cover property (e_cfg);
endmodule

// ===== src/dma4_fit.sv
// Beat size chooser: largest of 4, 2, 1 bytes allowed by address and limits
// Assumes remain is at least one byte
`timescale 1ns/1ps
module dma4_fit (
  input  wire logic [1:0]  addr_lo,
  input  wire logic [2:0]  max_bytes,
  input  wire logic [23:0] remain,
  output logic      [2:0]  fit_bytes
);
  // ------------------------------------------------------------------
  // Size selection
  // ------------------------------------------------------------------
  logic ok4;
  logic ok2;

  // A size fits when width, remaining count and address all allow it
  assign ok4       = (max_bytes >= 3'h4) & (remain >= 24'h00_0004) & (addr_lo == 2'h0);
  assign ok2       = (max_bytes >= 3'h2) & (remain >= 24'h00_0002) & ~addr_lo[0];
  assign fit_bytes = ok4 ? 3'h4 : ok2 ? 3'h2 : 3'h1;
endmodule

// ===== src/dma4_pkg.sv
// Shared constants for the four-channel DMA: map, fields, sizes, states
// Assumes APB byte addressing, 32-bit data, channels 16 bytes apart
package dma4_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam int          NCH      = 4;
  localparam logic [3:0]  OFF_SAR  = 4'h0;
  localparam logic [3:0]  OFF_DAR  = 4'h4;
  localparam logic [3:0]  OFF_DSR  = 4'h8;
  localparam logic [3:0]  OFF_DCR  = 4'hc;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [31:0] DCR_MASK = 32'hf07f_0080;
  localparam logic [23:0] AA_LIMIT = 24'h00_0010;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int DCR_IRQ_ON_COMPLETION_ENABLE  = 31;
  localparam int DCR_ERQ   = 30;
  localparam int DCR_CS    = 29;
  localparam int DCR_AA    = 28;
  localparam int DCR_SOURCE_INCREMENT  = 22;
  localparam int DCR_SSZ   = 20;
  localparam int DCR_DEST_INCREMENT  = 19;
  localparam int DCR_DSZ   = 17;
  localparam int DCR_START = 16;
  localparam int DCR_DREQ  = 7;
  localparam int DSR_DONE  = 24;

  // ------------------------------------------------------------------
  // Width codes and helpers
  // ------------------------------------------------------------------
  localparam logic [1:0] SZ_32 = 2'h0;
  localparam logic [1:0] SZ_8  = 2'h1;
  localparam logic [1:0] SZ_16 = 2'h2;

  // Bytes moved by one beat of a width code
  function automatic logic [2:0] bytes_of(input logic [1:0] sz);
    return (sz == SZ_8) ? 3'h1 : (sz == SZ_16) ? 3'h2 : 3'h4;
  endfunction

  // Address low bits not on a boundary of b bytes
  function automatic logic misaligned(input logic [1:0] a, input logic [2:0] b);
    return |(a & (b[1:0] - 2'h1));
  endfunction

  // Byte lanes that carry a beat of b bytes
  function automatic logic [31:0] lane_mask(input logic [2:0] b);
    return (b == 3'h1) ? 32'h0000_00ff : (b == 3'h2) ? 32'h0000_ffff : 32'hffff_ffff;
  endfunction

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_CHECK   = 3'h1,
    ST_RD_SET  = 3'h2,
    ST_RD_WAIT = 3'h3,
    ST_WR_SET  = 3'h4,
    ST_WR_WAIT = 3'h5,
    ST_NEXT    = 3'h6
  } dma4_state_t;

endpackage

// ===== tb/dma4_bus_model.sv
// System bus slave model for the DMA: fixed byte pattern, varying wait, error on demand
// Assumes one request at a time, held by the DMA until answered
`timescale 1ns/1ps
module dma4_bus_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        bus_req,
  input  wire logic        bus_wr,
  input  wire logic [31:0] bus_addr,
  input  wire logic [2:0]  bus_bytes,
  input  wire logic [31:0] bus_wdata,
  input  wire logic        err_on,
  output logic      [31:0] bus_rdata,
  output logic             bus_ack,
  output logic             bus_err,
  output logic      [31:0] wr_addr,
  output logic      [31:0] wr_data,
  output logic      [7:0]  wr_cnt
);
  logic [1:0] wait_q;

  // Byte at address a holds a low byte xor 5a, low lanes first
  function automatic logic [31:0] pat(input logic [31:0] a, input logic [2:0] n);
    pat = 32'h0;
    for (int k = 0; k < n; k++) pat[8*k +: 8] = (a[7:0] + 8'(k)) ^ 8'h5a;
  endfunction

  // Answer once per request after an address-dependent wait; idle data toggles
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      wait_q    <= 2'h0;
      bus_ack   <= 1'b0;
      bus_err   <= 1'b0;
      bus_rdata <= 32'h0;
      wr_addr   <= 32'h0;
      wr_data   <= 32'h0;
      wr_cnt    <= 8'h0;
    end
    else if (bus_req && !bus_ack && !bus_err && wait_q == 2'h0)
    begin
      bus_ack   <= !err_on;
      bus_err   <= err_on;
      bus_rdata <= pat(bus_addr, bus_bytes);
      wait_q    <= bus_addr[3:2];
      wr_addr   <= bus_wr ? bus_addr : wr_addr;
      wr_data   <= bus_wr ? bus_wdata : wr_data;
      wr_cnt    <= wr_cnt + 8'(bus_wr && !err_on);
    end
    else
    begin
      bus_ack   <= 1'b0;
      bus_err   <= 1'b0;
      bus_rdata <= ~bus_rdata;
      wait_q    <= wait_q - 2'(bus_req && wait_q != 2'h0);
    end
endmodule

// ===== tb/tb_dma4_core.sv
// Self-checking bench for the four-channel DMA core over APB
// Assumes the bus model file is compiled first
`timescale 1ns/1ps
module tb_dma4_core;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slv, err_on;
  logic        bus_req, bus_wr, bus_ack, bus_err;
  logic [7:0]  paddr, wr_cnt, n0;
  logic [3:0]  periph_req, irq;
  logic [2:0]  bus_bytes;
  logic [31:0] pwdata, prdata, bus_addr, bus_wdata, bus_rdata, wr_addr, wr_data, rd, s, d;
  logic [31:0] seed = 32'h0000_002b;
  int          err_count, checks_done, cyc;

  dma4_core dma4_core_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .periph_req, .bus_req, .bus_wr, .bus_addr, .bus_bytes, .bus_wdata,
    .bus_rdata, .bus_ack, .bus_err, .irq);
  dma4_bus_model dma4_bus_model_i (.pclk, .presetn, .bus_req, .bus_wr, .bus_addr, .bus_bytes,
    .bus_wdata, .err_on, .bus_rdata, .bus_ack, .bus_err, .wr_addr, .wr_data, .wr_cnt);

  // Clock and hang limit
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      tally_and_finish;
    end
  end

  // --------------------------------------------------------------
  // Expectation helpers and bus tasks
  // --------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function automatic logic [31:0] pat(input logic [31:0] a, input logic [2:0] n);
    pat = 32'h0;
    for (int k = 0; k < n; k++) pat[8*k +: 8] = (a[7:0] + 8'(k)) ^ 8'h5a;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd      = prdata;
    slv     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wrr(input logic [1:0] ch, input logic [3:0] off, input logic [31:0] v);
    apb(1'b1, {2'h0, ch, off}, v);
  endtask
  task automatic rdr(input logic [1:0] ch, input logic [3:0] off);
    apb(1'b0, {2'h0, ch, off}, 32'h0);
  endtask
  task automatic prog(input logic [1:0] ch, input logic [31:0] sa, da, cnt, ctl);
    wrr(ch, dma4_pkg::OFF_SAR, sa);
    wrr(ch, dma4_pkg::OFF_DAR, da);
    wrr(ch, dma4_pkg::OFF_DSR, 32'h0100_0000 | cnt);
    wrr(ch, dma4_pkg::OFF_DCR, ctl);
  endtask
  task automatic wait_done(input logic [1:0] ch);
    do rdr(ch, dma4_pkg::OFF_DSR); while (rd[24] !== 1'b1);
  endtask
  task automatic wait_wr(input logic [7:0] n);
    while (wr_cnt !== n) @(posedge pclk);
    repeat (4) @(posedge pclk);
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, periph_req, err_on, presetn} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    s = rnd() & 32'h0000_fffc;
    d = rnd() & 32'h0000_fffc;
    prog(2'h0, s, d, 32'h8, 32'ha049_0000);
    wait_wr(8'h1);
    chk(wr_addr, d);
    chk(wr_data, pat(s, 3'h4));
    rdr(2'h0, dma4_pkg::OFF_SAR);
    chk(rd, s + 32'h4);
    rdr(2'h0, dma4_pkg::OFF_DSR);
    chk(rd & 32'h01ff_ffff, 32'h4);
    rdr(2'h0, dma4_pkg::OFF_DCR);
    chk(32'(rd[16]), 32'h0);
    wrr(2'h0, dma4_pkg::OFF_DCR, 32'ha049_0000);
    wait_wr(8'h2);
    rdr(2'h0, dma4_pkg::OFF_DSR);
    chk(rd & 32'h71ff_ffff, 32'h0100_0000);
    chk(32'(irq), 32'h1);
    wrr(2'h0, dma4_pkg::OFF_DSR, 32'h0100_0000);
    @(posedge pclk);
    chk(32'(irq), 32'h0);
    $display("cycle steal test ended");
    s = rnd() & 32'h0000_ffff;
    n0 = wr_cnt;
    prog(2'h3, s, d, 32'h8, 32'h0059_0000);
    wait_done(2'h3);
    chk(32'(wr_cnt), 32'(n0 + 8'h2));
    chk(wr_data, pat(s + 32'h4, 3'h4));
    chk(wr_addr, d + 32'h4);
    $display("continuous test ended");
    prog(2'h1, s | 32'h1, d, 32'h4, 32'h0001_0000);
    wait_done(2'h1);
    chk(32'(rd[30]), 32'h1);
    chk(32'(wr_cnt), 32'(n0 + 8'h2));
    err_on <= 1'b1;
    prog(2'h1, s & 32'hffff_fffc, d, 32'h4, 32'h0001_0000);
    wait_done(2'h1);
    chk(rd & 32'h7100_0000, 32'h2100_0000);
    err_on <= 1'b0;
    $display("error test ended");
    prog(2'h1, s & 32'hffff_fffc, d, 32'h4, 32'h4048_0080);
    prog(2'h2, s & 32'hffff_fffc, d + 32'h10, 32'h4, 32'h4048_0080);
    chk(32'(wr_cnt), 32'(n0 + 8'h2));
    periph_req <= 4'h6;
    wait_done(2'h2);
    periph_req <= 4'h0;
    chk(wr_addr, d + 32'h10);
    rdr(2'h2, dma4_pkg::OFF_DCR);
    chk(32'(rd[30]), 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk(32'(slv), 32'h1);
    $display("priority test ended");
    tally_and_finish;
  end
endmodule
